// File: src/usr_uart_top.sv
/*
 * Serial port with status/control and receive data registers behind a
 * classic Wishbone slave, a receive buffer, a baud tick generator and a
 * masked interrupt. Assumes one clock and a synchronous active-high reset;
 * the serial receive pin is asynchronous and is synchronised in usr_rx.
 */
module usr_uart_top #(
	parameter int DEPTH = 4,
	parameter int AW = 8
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [AW-1:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	input wire logic i_serial_rx_input,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	output logic o_irq,
	output logic o_serial_tx_output
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);
	localparam logic [PW:0] CNT_3Q = (PW + 1)'(DEPTH - 1);

	logic req;
	logic wr;
	logic rd;
	logic [7:0] adr;
	logic [15:0] status;
	logic tick;
	logic [15:0] baud_q;
	logic [15:0] bcnt_q;
	logic tx_irq_sel_q;
	logic tx_brk_q;
	logic tx_en_q;
	logic [1:0] rx_irq_sel_q;
	logic addr_en_q;
	logic nine_q;
	logic overrun_q;
	logic ferr_q;
	logic [usr_pkg::CHAR_W-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [PW:0] count_q;
	logic push;
	logic pop;
	logic overrun_set;
	logic rx_valid;
	logic [usr_pkg::CHAR_W-1:0] rx_data;
	logic rx_ferr;
	logic rx_idle;
	logic txb_full_q;
	logic [usr_pkg::CHAR_W-1:0] txb_q;
	logic tx_ready;
	logic tx_line;
	logic tx_idle;
	logic tx_load;
	logic trmt;
	logic trmt_q;
	logic [usr_pkg::EV_W-1:0] ev;
	logic [usr_pkg::EV_W-1:0] irq_st_q;
	logic [usr_pkg::EV_W-1:0] irq_mask_q;
	logic rx_ev;

	// One-cycle answer: the request is taken in the cycle it appears
	assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign wr = req && i_wb_we;
	assign rd = req && !i_wb_we;
	assign adr = {i_wb_adr[7:2], 2'b00};

	assign tick = (bcnt_q == baud_q);
	assign overrun_set = rx_valid && (count_q == CNT_FULL);
	assign push = rx_valid && (count_q != CNT_FULL);
	assign pop = rd && (adr == usr_pkg::OFS_RXDATA) && (count_q != '0);
	assign tx_load = txb_full_q && tx_ready;
	assign trmt = !txb_full_q && tx_idle;

	always_comb begin
		status = 16'h0000;
		status[usr_pkg::ST_TX_IRQ_SEL] = tx_irq_sel_q;
		status[usr_pkg::ST_TX_BREAK] = tx_brk_q;
		status[usr_pkg::ST_TX_ENABLE] = tx_en_q;
		status[usr_pkg::ST_TX_BUF_FULL] = txb_full_q;
		status[usr_pkg::ST_TX_SHIFT_EMPTY] = trmt;
		status[usr_pkg::ST_RX_IRQ_SEL_HI] = rx_irq_sel_q[1];
		status[usr_pkg::ST_RX_IRQ_SEL_LO] = rx_irq_sel_q[0];
		status[usr_pkg::ST_ADDR_DETECT] = addr_en_q;
		status[usr_pkg::ST_RX_IDLE] = rx_idle;
		status[usr_pkg::ST_FRAME_ERR] = ferr_q;
		status[usr_pkg::ST_OVERRUN] = overrun_q;
		status[usr_pkg::ST_DATA_AVAIL] = (count_q != '0);
	end

	// A new divisor restarts the tick timer at once
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			bcnt_q <= 16'h0000;
		end else if ((wr && adr == usr_pkg::OFS_BAUD) || tick) begin
			bcnt_q <= 16'h0000;
		end else begin
			bcnt_q <= bcnt_q + 16'h0001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			baud_q <= usr_pkg::BAUD_RST;
		end else if (wr && adr == usr_pkg::OFS_BAUD) begin
			if (i_wb_sel[0]) begin
				baud_q[7:0] <= i_wb_dat[7:0];
			end
			if (i_wb_sel[1]) begin
				baud_q[15:8] <= i_wb_dat[15:8];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			tx_irq_sel_q <= 1'b0;
			tx_brk_q <= 1'b0;
			tx_en_q <= 1'b0;
			rx_irq_sel_q <= 2'b00;
			addr_en_q <= 1'b0;
			nine_q <= 1'b0;
		end else if (wr) begin
			if (adr == usr_pkg::OFS_STATUS && i_wb_sel[1]) begin
				tx_irq_sel_q <= i_wb_dat[usr_pkg::ST_TX_IRQ_SEL];
				tx_brk_q <= i_wb_dat[usr_pkg::ST_TX_BREAK];
				tx_en_q <= i_wb_dat[usr_pkg::ST_TX_ENABLE];
			end
			if (adr == usr_pkg::OFS_STATUS && i_wb_sel[0]) begin
				rx_irq_sel_q <= i_wb_dat[usr_pkg::ST_RX_IRQ_SEL_HI:usr_pkg::ST_RX_IRQ_SEL_LO];
				addr_en_q <= i_wb_dat[usr_pkg::ST_ADDR_DETECT];
			end
			if (adr == usr_pkg::OFS_CONFIG && i_wb_sel[0]) begin
				nine_q <= i_wb_dat[usr_pkg::CFG_NINE_BIT];
			end
		end
	end

	// Only hardware sets the overrun flag; a zero written clears it, set wins
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			overrun_q <= 1'b0;
		end else if (overrun_set) begin
			overrun_q <= 1'b1;
		end else if (wr && adr == usr_pkg::OFS_STATUS && i_wb_sel[0] && !i_wb_dat[usr_pkg::ST_OVERRUN]) begin
			overrun_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ferr_q <= 1'b0;
		end else if (rx_valid) begin
			ferr_q <= rx_ferr;
		end
	end

	// Receive buffer; a character arriving while full is dropped
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_q] <= rx_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + PW'(1);
			end
			if (push && !pop) begin
				count_q <= count_q + (PW + 1)'(1);
			end else if (pop && !push) begin
				count_q <= count_q - (PW + 1)'(1);
			end
		end
	end

	// Transmit holding word; a write while full is ignored
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			txb_full_q <= 1'b0;
			txb_q <= '0;
		end else if (tx_load) begin
			txb_full_q <= 1'b0;
		end else if (wr && adr == usr_pkg::OFS_TXDATA && tx_en_q && !txb_full_q) begin
			txb_full_q <= 1'b1;
			txb_q <= i_wb_dat[usr_pkg::CHAR_W-1:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_serial_tx_output <= 1'b1;
		end else begin
			o_serial_tx_output <= tx_brk_q ? 1'b0 : (tx_en_q ? tx_line : 1'b1);
		end
	end

	// Interrupt events; reading the event register clears it, set wins
	assign rx_ev = push && (!rx_irq_sel_q[1]
		|| (count_q + (PW + 1)'(1) == (rx_irq_sel_q[0] ? CNT_FULL : CNT_3Q)));
	assign ev = {(tx_irq_sel_q ? (trmt && !trmt_q) : tx_load), rx_valid && rx_ferr, overrun_set, rx_ev};

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			trmt_q <= 1'b1;
			irq_st_q <= '0;
			irq_mask_q <= usr_pkg::IRQ_MASK_RST;
			o_irq <= 1'b0;
		end else begin
			trmt_q <= trmt;
			irq_st_q <= ((rd && adr == usr_pkg::OFS_IRQ_STATUS) ? '0 : irq_st_q) | ev;
			if (wr && adr == usr_pkg::OFS_IRQ_MASK && i_wb_sel[0]) begin
				irq_mask_q <= i_wb_dat[usr_pkg::EV_W-1:0];
			end
			o_irq <= |(irq_st_q & irq_mask_q);
		end
	end

	// Bus answer; unmapped addresses read zero and ignore writes
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			o_wb_ack <= req;
			o_wb_dat <= 32'h0000_0000;
			if (rd) begin
				unique case (adr)
					usr_pkg::OFS_STATUS: o_wb_dat <= {16'h0000, status};
					usr_pkg::OFS_RXDATA: o_wb_dat <= {23'h000000, mem[rd_ptr_q]};
					usr_pkg::OFS_BAUD: o_wb_dat <= {16'h0000, baud_q};
					usr_pkg::OFS_CONFIG: o_wb_dat <= {31'h00000000, nine_q};
					usr_pkg::OFS_IRQ_STATUS: o_wb_dat <= {28'h0000000, irq_st_q};
					usr_pkg::OFS_IRQ_MASK: o_wb_dat <= {28'h0000000, irq_mask_q};
					default: o_wb_dat <= 32'h0000_0000;
				endcase
			end
		end
	end

	usr_rx u_rx (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_tick(tick),
		.i_nine(nine_q),
		.i_rx(i_serial_rx_input),
		.o_valid(rx_valid),
		.o_data(rx_data),
		.o_frame_err(rx_ferr),
		.o_idle(rx_idle)
	);

	usr_tx u_tx (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_tick(tick),
		.i_nine(nine_q),
		.i_valid(txb_full_q),
		.i_data(txb_q),
		.o_ready(tx_ready),
		.o_line(tx_line),
		.o_idle(tx_idle)
	);

	logic rxd_req;
	assign rxd_req = rd && (adr == usr_pkg::OFS_RXDATA);

	logic [usr_pkg::CHAR_W-1:0] last_push_q;

	// Newest character taken into the buffer; a lone entry must read back as this
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			last_push_q <= '0;
		end else if (push) begin
			last_push_q <= rx_data;
		end
	end

	sequence seq_only_char;
		rxd_req && count_q == (PW + 1)'(1);
	endsequence

	a_overrun_on_full: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(rx_valid && count_q == CNT_FULL) |=> overrun_q && count_q == ($past(pop) ? CNT_3Q : CNT_FULL))
		else $error("overrun flag not set on full buffer");
	a_overrun_set_cause: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		$rose(overrun_q) |-> $past(overrun_set))
		else $error("overrun flag set without an overflow");
	a_overrun_write_one: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(wr && adr == usr_pkg::OFS_STATUS && i_wb_dat[1] && !overrun_q && !overrun_set) |=> !overrun_q)
		else $error("writing one set the overrun flag");
	a_avail_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(rd && adr == usr_pkg::OFS_STATUS) |=> o_wb_ack && o_wb_dat[0] == ($past(count_q) != '0))
		else $error("data available flag wrong");
	a_rxd_ninth_bit: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		seq_only_char |=> o_wb_dat[usr_pkg::RXD_NINTH] == $past(last_push_q[usr_pkg::RXD_NINTH]))
		else $error("ninth received bit wrong");
	a_rxd_low_byte: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		seq_only_char |=> o_wb_dat[7:0] == $past(last_push_q[7:0]))
		else $error("received low byte wrong");
	a_rxd_upper_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		rxd_req |=> o_wb_dat[31:9] == '0)
		else $error("receive data upper bits not zero");
	a_break_forces_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		tx_brk_q [*2] |-> !o_serial_tx_output)
		else $error("break did not hold transmit output low");
	a_irq_level: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_irq == $past(|(irq_st_q & irq_mask_q)))
		else $error("interrupt output does not follow masked status");
endmodule : usr_uart_top

// File: common/usr_pkg.sv
/*
 * Shared constants for the serial port status and receive block: register
 * byte offsets, status field positions, reset values and bit timing.
 * Assumes a 32-bit classic Wishbone register bus with byte addressing.
 */
package usr_pkg;
	// Register byte offsets (word aligned)
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_RXDATA = 8'h04;
	localparam logic [7:0] OFS_TXDATA = 8'h08;
	localparam logic [7:0] OFS_BAUD = 8'h0C;
	localparam logic [7:0] OFS_CONFIG = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

	// Status and control field positions
	localparam int ST_TX_IRQ_SEL = 15;
	localparam int ST_TX_BREAK = 11;
	localparam int ST_TX_ENABLE = 10;
	localparam int ST_TX_BUF_FULL = 9;
	localparam int ST_TX_SHIFT_EMPTY = 8;
	localparam int ST_RX_IRQ_SEL_HI = 7;
	localparam int ST_RX_IRQ_SEL_LO = 6;
	localparam int ST_ADDR_DETECT = 5;
	localparam int ST_RX_IDLE = 4;
	localparam int ST_FRAME_ERR = 2;
	localparam int ST_OVERRUN = 1;
	localparam int ST_DATA_AVAIL = 0;

	// Receive data layout
	localparam int RXD_NINTH = 8;
	localparam int CHAR_W = 9;

	// Configuration field
	localparam int CFG_NINE_BIT = 0;

	// Interrupt event bits
	localparam int EV_RX_CHAR = 0;
	localparam int EV_OVERRUN = 1;
	localparam int EV_FRAME_ERR = 2;
	localparam int EV_TX = 3;
	localparam int EV_W = 4;

	// Reset values
	localparam logic [15:0] BAUD_RST = 16'h0000;
	localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;

	// Oversampling: sixteen ticks per bit, start bit checked at mid-bit
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] OVS_MID = 4'h7;
	localparam logic [3:0] RX_BITS8 = 4'h8;
	localparam logic [3:0] RX_BITS9 = 4'h9;
	localparam logic [3:0] TX_BITS8 = 4'hA;
	localparam logic [3:0] TX_BITS9 = 4'hB;
endpackage : usr_pkg

// File: src/usr_rx.sv
/*
 * Serial receiver: finds the start bit, samples each bit at mid-bit on a
 * sixteen times oversampling tick and hands over one character per frame.
 * Assumes i_tick is a one-cycle pulse at sixteen times the bit rate.
 */
module usr_rx (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_tick,
	input wire logic i_nine,
	input wire logic i_rx,
	output logic o_valid,
	output logic [usr_pkg::CHAR_W-1:0] o_data,
	output logic o_frame_err,
	output logic o_idle
);
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usr_rx_state_t;

	usr_rx_state_t state_q;
	logic sync1_q;
	logic sync2_q;
	logic [3:0] tcnt_q;
	logic [3:0] bit_q;
	logic [usr_pkg::CHAR_W-1:0] shift_q;
	logic [3:0] last_bit;

	assign last_bit = i_nine ? usr_pkg::RX_BITS9 : usr_pkg::RX_BITS8;
	assign o_idle = (state_q == RX_IDLE);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= i_rx;
			sync2_q <= sync1_q;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_q <= RX_IDLE;
			tcnt_q <= 4'h0;
			bit_q <= 4'h0;
			shift_q <= '0;
			o_valid <= 1'b0;
			o_data <= '0;
			o_frame_err <= 1'b0;
		end else begin
			o_valid <= 1'b0;
			unique case (state_q)
				RX_IDLE: begin
					tcnt_q <= 4'h0;
					if (!sync2_q) begin
						state_q <= RX_START;
					end
				end
				RX_START: begin
					if (i_tick) begin
						if (tcnt_q == usr_pkg::OVS_MID) begin
							// A glitch shorter than half a bit is not a start
							state_q <= sync2_q ? RX_IDLE : RX_DATA;
							tcnt_q <= 4'h0;
							bit_q <= 4'h0;
						end else begin
							tcnt_q <= tcnt_q + 4'h1;
						end
					end
				end
				RX_DATA: begin
					if (i_tick) begin
						tcnt_q <= tcnt_q + 4'h1;
						if (tcnt_q == usr_pkg::OVS_LAST) begin
							shift_q <= {sync2_q, shift_q[usr_pkg::CHAR_W-1:1]};
							bit_q <= bit_q + 4'h1;
							if (bit_q + 4'h1 == last_bit) begin
								state_q <= RX_STOP;
							end
						end
					end
				end
				RX_STOP: begin
					if (i_tick) begin
						tcnt_q <= tcnt_q + 4'h1;
						if (tcnt_q == usr_pkg::OVS_LAST) begin
							o_valid <= 1'b1;
							o_frame_err <= !sync2_q;
							o_data <= i_nine ? shift_q : {1'b0, shift_q[usr_pkg::CHAR_W-1:1]};
							state_q <= RX_IDLE;
						end
					end
				end
			endcase
		end
	end
endmodule : usr_rx

// File: src/usr_tx.sv
/*
 * Serial transmitter: sends start bit, eight or nine data bits LSB first
 * and one stop bit. Assumes i_tick at sixteen times the bit rate.
 */
module usr_tx (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_tick,
	input wire logic i_nine,
	input wire logic i_valid,
	input wire logic [usr_pkg::CHAR_W-1:0] i_data,
	output logic o_ready,
	output logic o_line,
	output logic o_idle
);
	logic busy_q;
	logic [10:0] frame_q;
	logic [3:0] tcnt_q;
	logic [3:0] left_q;

	assign o_ready = !busy_q;
	assign o_idle = !busy_q;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			busy_q <= 1'b0;
			frame_q <= '1;
			tcnt_q <= 4'h0;
			left_q <= 4'h0;
			o_line <= 1'b1;
		end else if (!busy_q) begin
			o_line <= 1'b1;
			tcnt_q <= 4'h0;
			if (i_valid) begin
				busy_q <= 1'b1;
				frame_q <= i_nine ? {1'b1, i_data, 1'b0} : {2'b11, i_data[7:0], 1'b0};
				left_q <= i_nine ? usr_pkg::TX_BITS9 : usr_pkg::TX_BITS8;
			end
		end else begin
			o_line <= frame_q[0];
			if (i_tick) begin
				tcnt_q <= tcnt_q + 4'h1;
				if (tcnt_q == usr_pkg::OVS_LAST) begin
					frame_q <= {1'b1, frame_q[10:1]};
					left_q <= left_q - 4'h1;
					if (left_q == 4'h1) begin
						busy_q <= 1'b0;
					end
				end
			end
		end
	end
endmodule : usr_tx

// File: testbench/usr_remote_tx.sv
/*
 * Remote serial transmitter: sends 8N1 or 9N1 characters, LSB first,
 * into the receive pin of the serial port.
 * Assumes a baud divisor of zero on the far side, so sixteen clocks a bit,
 * and that send is called just after a rising clock edge.
 */
module usr_remote_tx (
	input wire logic i_clk,
	output logic o_line
);
	timeunit 1ns;
	timeprecision 1ps;

	localparam int BIT_CYC = 16;

	// The receive line starts high here and idles high between frames
	initial o_line = 1'b1;

	task automatic send(input logic [8:0] ch, input logic nine, input int gap);
		int n;
		int b;
		begin
			n = nine ? 9 : 8;
			for (b = -1; b <= n; b++) begin
				o_line <= (b < 0) ? 1'b0 : ((b == n) ? 1'b1 : ch[b]);
				repeat (BIT_CYC) @(posedge i_clk);
			end
			// A gap of zero sends the next start bit straight after the stop bit
			repeat (gap) @(posedge i_clk);
		end
	endtask : send
endmodule : usr_remote_tx

// File: testbench/usr_uart_top_tb.sv
/*
 * Self-checking bench for the serial port registers: Wishbone read and write
 * tasks, a remote transmitter model and sequences with expected values.
 * Assumes the design's package offsets and a receive buffer depth of four.
 */
module usr_uart_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_wdat = 32'h00000000;
	logic [3:0] wb_sel = 4'h0;
	logic rx_line;
	logic [31:0] wb_rdat;
	logic wb_ack;
	logic irq;
	logic tx_line;
	logic [31:0] rd;
	logic [8:0] ch;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	localparam logic [8:0] NINE_SET [3] = '{9'h1FF, 9'h15A, 9'h0C3};

	always #5 i_clk = ~i_clk;

	usr_uart_top #(.DEPTH(4), .AW(8)) uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(wb_cyc),
		.i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_dat(wb_wdat), .i_wb_sel(wb_sel),
		.i_serial_rx_input(rx_line), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .o_irq(irq),
		.o_serial_tx_output(tx_line));

	usr_remote_tx rem (.i_clk(i_clk), .o_line(rx_line));

	task automatic print_verdict();
		if (fail_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict

	// Whole run needs a few thousand cycles; this ceiling leaves ample slack
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 30000) begin
			fail_count++;
			print_verdict();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wb_cycle(input logic [7:0] a, input logic we, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] q);
		int n;
		begin
			n = 0;
			wb_cyc <= 1'b1;
			wb_stb <= 1'b1;
			wb_we <= we;
			wb_adr <= a;
			wb_wdat <= d;
			wb_sel <= s;
			do begin
				@(posedge i_clk);
				n++;
			end while (wb_ack !== 1'b1 && n < 100);
			if (n >= 100) begin
				fail_count++;
				$display("ERROR wb_ack expected 1 seen %b", wb_ack);
			end
			q = wb_rdat;
			wb_cyc <= 1'b0;
			wb_stb <= 1'b0;
			wb_we <= 1'b0;
			@(posedge i_clk);
		end
	endtask : wb_cycle

	task automatic wb_read(input logic [7:0] a, output logic [31:0] q);
		wb_cycle(a, 1'b0, 32'h00000000, 4'hF, q);
	endtask : wb_read

	task automatic wb_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		wb_cycle(a, 1'b1, d, s, q);
	endtask : wb_write

	// Polls a status bit until it sets, giving up after a bounded number of reads
	task automatic wait_status(input int idx);
		logic [31:0] q;
		int n;
		begin
			n = 0;
			do begin
				wb_read(usr_pkg::OFS_STATUS, q);
				n++;
			end while (q[idx] !== 1'b1 && n < 400);
			chk("status_wait", 32'h00000001, {31'h0, q[idx]});
		end
	endtask : wait_status

	initial begin
		repeat (4) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_clk);
		wb_read(usr_pkg::OFS_STATUS, rd);
		chk("status_reset", 32'h00000110, rd);
		wb_read(8'h1C, rd);
		chk("unmapped_read", 32'h00000000, rd);
		rem.send(9'h1A5, 1'b0, 0);
		wait_status(usr_pkg::ST_DATA_AVAIL);
		wb_read(usr_pkg::OFS_RXDATA, rd);
		chk("rx_eight_bit", 32'h000000A5, rd);
		wb_read(usr_pkg::OFS_STATUS, rd);
		chk("status_drained", 32'h00000000, {30'h0, rd[1:0]});
		wb_write(usr_pkg::OFS_CONFIG, 32'h00000001, 4'h1);
		for (int i = 0; i < 3; i++) begin
			rem.send(NINE_SET[i], 1'b1, 0);
			wait_status(usr_pkg::ST_DATA_AVAIL);
			wb_read(usr_pkg::OFS_RXDATA, rd);
			chk("rx_nine_bit", {23'h0, NINE_SET[i]}, rd);
		end
		wb_read(usr_pkg::OFS_IRQ_STATUS, rd);
		// Five characters into a four-deep buffer: the last one overruns
		for (int i = 0; i < 5; i++) begin
			rem.send({1'b1, 8'h10 + 8'(i)}, 1'b1, 0);
		end
		wait_status(usr_pkg::ST_OVERRUN);
		chk("irq_masked", 32'h00000000, {31'h0, irq});
		wb_write(usr_pkg::OFS_IRQ_MASK, 32'h00000002, 4'h1);
		repeat (2) @(posedge i_clk);
		chk("irq_raised", 32'h00000001, {31'h0, irq});
		wb_write(usr_pkg::OFS_STATUS, 32'h00000002, 4'h3);
		wb_read(usr_pkg::OFS_STATUS, rd);
		chk("overrun_kept", 32'h00000003, {30'h0, rd[1:0]});
		wb_write(usr_pkg::OFS_STATUS, 32'h00000000, 4'h3);
		wb_read(usr_pkg::OFS_STATUS, rd);
		chk("overrun_clear", 32'h00000001, {30'h0, rd[1:0]});
		wb_write(usr_pkg::OFS_STATUS, 32'h00000002, 4'h3);
		wb_read(usr_pkg::OFS_STATUS, rd);
		chk("overrun_no_set", 32'h00000001, {30'h0, rd[1:0]});
		for (int i = 0; i < 4; i++) begin
			ch = {1'b1, 8'h10 + 8'(i)};
			wb_read(usr_pkg::OFS_RXDATA, rd);
			chk("rx_oldest_first", {23'h0, ch}, rd);
		end
		wb_read(usr_pkg::OFS_STATUS, rd);
		chk("status_empty", 32'h00000000, {30'h0, rd[1:0]});
		wb_read(usr_pkg::OFS_IRQ_STATUS, rd);
		chk("irq_status", 32'h00000003, rd);
		repeat (2) @(posedge i_clk);
		chk("irq_cleared", 32'h00000000, {31'h0, irq});
		chk("tx_idle", 32'h00000001, {31'h0, tx_line});
		wb_write(usr_pkg::OFS_STATUS, 32'h00000800, 4'h3);
		repeat (2) @(posedge i_clk);
		chk("tx_break", 32'h00000000, {31'h0, tx_line});
		repeat (50) @(posedge i_clk);
		chk("tx_break_held", 32'h00000000, {31'h0, tx_line});
		wb_write(usr_pkg::OFS_STATUS, 32'h00000000, 4'h3);
		repeat (2) @(posedge i_clk);
		chk("tx_released", 32'h00000001, {31'h0, tx_line});
		// Break laid over a frame of all ones shows the line is forced, not driven
		wb_write(usr_pkg::OFS_STATUS, 32'h00000400, 4'h3);
		wb_write(usr_pkg::OFS_TXDATA, 32'h000001FF, 4'h3);
		wb_write(usr_pkg::OFS_STATUS, 32'h00000C00, 4'h3);
		repeat (20) @(posedge i_clk);
		wb_read(usr_pkg::OFS_STATUS, rd);
		chk("tx_break_busy", 32'h00000C00, {20'h0, rd[11:8], 8'h0});
		chk("tx_break_frame", 32'h00000000, {31'h0, tx_line});
		wb_write(usr_pkg::OFS_STATUS, 32'h00000400, 4'h3);
		repeat (2) @(posedge i_clk);
		chk("tx_frame_resumed", 32'h00000001, {31'h0, tx_line});
		wait_status(usr_pkg::ST_TX_SHIFT_EMPTY);
		chk("tx_frame_done", 32'h00000001, {31'h0, tx_line});
		wb_write(usr_pkg::OFS_BAUD, 32'h00001234, 4'h3);
		wb_read(usr_pkg::OFS_BAUD, rd);
		chk("baud_readback", 32'h00001234, rd);
		print_verdict();
	end
endmodule : usr_uart_top_tb
